// File: hw/ext_portal_pkg.sv
/*
 * Constants for the extended register portal: bus offsets, setup fields,
 * extended register addresses, reset values and state encodings.
 * Assumes a single core clock domain and an Avalon-MM word-addressed slave.
 */
// Operation
// - Portal reaches 32 device addresses, each with 65,536 sixteen-bit registers.
// - Extended registers are reached only through the setup and data portal registers.
// - Only device 2h register 00h and device 7h register 3Ch are implemented.
// - Setup function data without increment makes data accesses hit the latched register.
// - Setup function data with increment makes data accesses hit latched register, advancing.
// - A data-phase write stores the value into the selected extended register.
// - A data-phase read returns the selected extended register contents.
// - LED register bit 4 read-write reset 0; bits 15:5 zero, 3:0 read 0001b.
// - Advertisement bit 2 read-write reset 1, 1000 Mbps; bits 15:3 read zero.
// - Advertisement bit 1 read-write reset 1, 100 Mbps; bit 0 reads zero.
package ext_portal_pkg;

    // ========================================================================
    // Bus map
    // ========================================================================
    localparam logic [3:0]  SETUP_OFFSET   = 4'h0;
    localparam logic [3:0]  DATA_OFFSET    = 4'h4;
    localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;

    // ========================================================================
    // Setup register fields
    // ========================================================================
    localparam int FUNC_HI = 15;
    localparam int FUNC_LO = 14;
    localparam int DEV_HI  = 4;
    localparam int DEV_LO  = 0;
    localparam logic [15:0] SETUP_WMASK = 16'hC01F;
    localparam logic [1:0]  FUNC_ADDR   = 2'h0;
    localparam logic [1:0]  FUNC_DATA   = 2'h1;
    localparam logic [1:0]  FUNC_INCR   = 2'h2;
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [15:0] REGADDR_RESET = 16'h0000;

    // ========================================================================
    // Extended registers
    // ========================================================================
    localparam logic [4:0]  LED_DEV       = 5'h02;
    localparam logic [15:0] LED_REG       = 16'h0000;
    localparam int          LED_SEL_BIT   = 4;
    localparam logic [15:0] LED_FIXED     = 16'h0001;
    localparam logic        LED_SEL_RESET = 1'b0;

    localparam logic [4:0]  ADV_DEV       = 5'h07;
    localparam logic [15:0] ADV_REG       = 16'h003C;
    localparam int          ADV_1000_BIT  = 2;
    localparam int          ADV_100_BIT   = 1;
    localparam logic        ADV_RESET     = 1'b1;

    // ========================================================================
    // Bus answer sequencing
    // ========================================================================
    typedef enum logic [1:0] {ST_IDLE, ST_ACK} bus_state_type;

endpackage

// File: hw/ext_reg_decode.sv
/*
 * Decodes a device and register address pair into the implemented
 * extended register selects.
 * Assumes address inputs are stable within the cycle of use.
 */
`timescale 1ns/10ps
module ext_reg_decode (
    // Address
    input  wire logic [4:0]  i_dev,
    input  wire logic [15:0] i_reg,
    // Selects
    output logic             o_led_hit,
    output logic             o_adv_hit
);
    // Full device and register widths are compared, so no other address aliases a hit.
    assign o_led_hit = (i_dev == ext_portal_pkg::LED_DEV)
                    && (i_reg == ext_portal_pkg::LED_REG);
    assign o_adv_hit = (i_dev == ext_portal_pkg::ADV_DEV)
                    && (i_reg == ext_portal_pkg::ADV_REG);
endmodule

// File: hw/ext_reg_bank.sv
/*
 * Holds the writable bits of the two implemented extended registers and
 * forms their read values. Writes to other addresses are dropped.
 * Assumes a one-cycle write strobe from the portal.
 */
`timescale 1ns/10ps
module ext_reg_bank (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    // Access
    input  wire logic        i_wr,
    input  wire logic        i_led_hit,
    input  wire logic        i_adv_hit,
    input  wire logic [15:0] i_wdata,
    // Read and state
    output logic      [15:0] o_rdata,
    output logic             o_led_sel,
    output logic             o_adv_1000,
    output logic             o_adv_100
);
    logic led_sel_ff;
    logic adv_1000_ff;
    logic adv_100_ff;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            led_sel_ff  <= ext_portal_pkg::LED_SEL_RESET;
            adv_1000_ff <= ext_portal_pkg::ADV_RESET;
            adv_100_ff  <= ext_portal_pkg::ADV_RESET;
        end else begin
            if (i_wr && i_led_hit) begin
                led_sel_ff <= i_wdata[ext_portal_pkg::LED_SEL_BIT];
            end
            if (i_wr && i_adv_hit) begin
                adv_1000_ff <= i_wdata[ext_portal_pkg::ADV_1000_BIT];
                adv_100_ff  <= i_wdata[ext_portal_pkg::ADV_100_BIT];
            end
        end
    end

    wire [15:0] led_value = ext_portal_pkg::LED_FIXED
                          | (16'(led_sel_ff) << ext_portal_pkg::LED_SEL_BIT);
    wire [15:0] adv_value = (16'(adv_1000_ff) << ext_portal_pkg::ADV_1000_BIT)
                          | (16'(adv_100_ff) << ext_portal_pkg::ADV_100_BIT);

    assign o_rdata    = i_led_hit ? led_value :
                        i_adv_hit ? adv_value : 16'h0000;
    assign o_led_sel  = led_sel_ff;
    assign o_adv_1000 = adv_1000_ff;
    assign o_adv_100  = adv_100_ff;
endmodule

// File: hw/ext_portal.sv
/*
 * Extended register portal: Avalon-MM slave with a setup and a data word.
 * The setup word selects address or data phase and the target device; the
 * data word latches a register address or reaches the selected register.
 * Assumes one core clock; bus inputs are synchronous to it.
 */
`timescale 1ns/10ps
module ext_portal (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    // Avalon-MM slave
    input  wire logic [3:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    // Register state
    output logic             o_led_style_select,
    output logic             o_eee_adv_1000,
    output logic             o_eee_adv_100
);
    // ========================================================================
    // Bus decode
    // ========================================================================
    ext_portal_pkg::bus_state_type state_ff;
    ext_portal_pkg::bus_state_type nxt_state;
    logic [15:0] setup_ff;
    logic [15:0] reg_addr_ff;
    logic [31:0] readdata_ff;
    logic        led_sel_ff;
    logic        adv_1000_ff;
    logic        adv_100_ff;

    // Merges a write into a word, keeping the byte lanes that are not enabled.
    function automatic logic [15:0] lane_merge(input logic [15:0] cur,
                                               input logic [15:0] wdata,
                                               input logic [1:0]  be);
        logic [15:0] mask;
        mask = {{8{be[1]}}, {8{be[0]}}};
        return (wdata & mask) | (cur & ~mask);
    endfunction

    wire         req       = i_read | i_write;
    wire         accept    = req && (state_ff == ext_portal_pkg::ST_IDLE);
    wire         hit_setup = (i_address == ext_portal_pkg::SETUP_OFFSET);
    wire         hit_data  = (i_address == ext_portal_pkg::DATA_OFFSET);
    wire [1:0]   func      = setup_ff[ext_portal_pkg::FUNC_HI:ext_portal_pkg::FUNC_LO];
    wire [4:0]   dev       = setup_ff[ext_portal_pkg::DEV_HI:ext_portal_pkg::DEV_LO];
    wire         data_fn   = (func == ext_portal_pkg::FUNC_DATA)
                           || (func == ext_portal_pkg::FUNC_INCR);
    wire         addr_fn   = (func == ext_portal_pkg::FUNC_ADDR);
    wire         data_acc  = accept && hit_data;
    wire         ext_wr    = data_acc && i_write && data_fn;
    wire         led_hit;
    wire         adv_hit;
    wire [15:0]  ext_rdata;

    // ========================================================================
    // Extended register decode and storage
    // ========================================================================
    ext_reg_decode i_ext_reg_decode (
        .i_dev     (dev),
        .i_reg     (reg_addr_ff),
        .o_led_hit (led_hit),
        .o_adv_hit (adv_hit)
    );

    ext_reg_bank i_ext_reg_bank (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_wr       (ext_wr),
        .i_led_hit  (led_hit),
        .i_adv_hit  (adv_hit),
        .i_wdata    (lane_merge(ext_rdata, i_writedata[15:0], i_byteenable[1:0])),
        .o_rdata    (ext_rdata),
        .o_led_sel  (),
        .o_adv_1000 (),
        .o_adv_100  ()
    );

    // ========================================================================
    // Read mux
    // ========================================================================
    wire [15:0] data_view = data_fn ? ext_rdata : reg_addr_ff;
    wire [31:0] rd_mux    = hit_setup ? {16'h0000, setup_ff} :
                            hit_data  ? {16'h0000, data_view} :
                                        ext_portal_pkg::UNMAPPED_VALUE;

    // Waitrequest is high except in the answer cycle, so every access takes two cycles.
    always_comb begin
        case (state_ff)
            ext_portal_pkg::ST_IDLE: begin
                nxt_state = req ? ext_portal_pkg::ST_ACK : ext_portal_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = ext_portal_pkg::ST_IDLE;
            end
        endcase
    end

    // ========================================================================
    // Portal state
    // ========================================================================
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff      <= ext_portal_pkg::ST_IDLE;
            o_waitrequest <= 1'b1;
            readdata_ff   <= 32'h0000_0000;
        end else begin
            state_ff      <= nxt_state;
            o_waitrequest <= ~accept;
            if (accept && i_read) begin
                readdata_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            setup_ff <= ext_portal_pkg::SETUP_RESET;
        end else if (accept && i_write && hit_setup) begin
            setup_ff <= lane_merge(setup_ff, i_writedata[15:0], i_byteenable[1:0])
                        & ext_portal_pkg::SETUP_WMASK;
        end
    end

    // Address phase latches the register; increment mode steps after every data word access.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            reg_addr_ff <= ext_portal_pkg::REGADDR_RESET;
        end else if (data_acc && addr_fn && i_write) begin
            reg_addr_ff <= lane_merge(reg_addr_ff, i_writedata[15:0], i_byteenable[1:0]);
        end else if (data_acc && func == ext_portal_pkg::FUNC_INCR) begin
            reg_addr_ff <= reg_addr_ff + 16'h0001;
        end
    end

    // Mirror the bank state so every top output comes from a local flip-flop.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            led_sel_ff  <= ext_portal_pkg::LED_SEL_RESET;
            adv_1000_ff <= ext_portal_pkg::ADV_RESET;
            adv_100_ff  <= ext_portal_pkg::ADV_RESET;
        end else if (ext_wr) begin
            if (led_hit) begin
                led_sel_ff <= ext_rdata[ext_portal_pkg::LED_SEL_BIT] ^
                              ((ext_rdata[ext_portal_pkg::LED_SEL_BIT]
                               ^ i_writedata[ext_portal_pkg::LED_SEL_BIT])
                               & i_byteenable[0]);
            end
            if (adv_hit && i_byteenable[0]) begin
                adv_1000_ff <= i_writedata[ext_portal_pkg::ADV_1000_BIT];
                adv_100_ff  <= i_writedata[ext_portal_pkg::ADV_100_BIT];
            end
        end
    end

    assign o_readdata         = readdata_ff;
    assign o_led_style_select = led_sel_ff;
    assign o_eee_adv_1000     = adv_1000_ff;
    assign o_eee_adv_100      = adv_100_ff;

    // ========================================================================
    // Checks
    // ========================================================================
    sequence led_write_s;
        ext_wr && led_hit && i_byteenable[0];
    endsequence

    sequence adv_write_s;
        ext_wr && adv_hit && i_byteenable[0];
    endsequence

    // One low answer cycle, then the slave is busy again until the next request.
    sequence answer_s;
        !o_waitrequest ##1 o_waitrequest;
    endsequence

    wait_answer_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        accept |=> answer_s)
        else $error("waitrequest did not answer in one cycle");
    led_store_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        led_write_s |=> o_led_style_select == $past(i_writedata[ext_portal_pkg::LED_SEL_BIT]))
        else $error("led select not stored");
    adv_store_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        adv_write_s |=> {o_eee_adv_1000, o_eee_adv_100} == $past(i_writedata[2:1]))
        else $error("advertisement bits not stored");
    incr_step_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (data_acc && func == ext_portal_pkg::FUNC_INCR) |=>
        reg_addr_ff == $past(reg_addr_ff) + 16'h0001)
        else $error("register address did not advance");
    hold_addr_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (data_acc && func == ext_portal_pkg::FUNC_DATA) |=> $stable(reg_addr_ff))
        else $error("register address moved without increment");
    addr_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (data_acc && addr_fn && i_write && i_byteenable[1:0] == 2'h3) |=>
        reg_addr_ff == $past(i_writedata[15:0]))
        else $error("register address not latched");
    led_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (accept && i_read && hit_data && data_fn && led_hit) |=>
        o_readdata == {27'h000_0000, o_led_style_select, 4'h1})
        else $error("led register read value wrong");
    adv_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (accept && i_read && hit_data && data_fn && adv_hit) |=>
        o_readdata == {29'h0000_0000, o_eee_adv_1000, o_eee_adv_100, 1'b0})
        else $error("advertisement register read value wrong");
    unmapped_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (accept && i_read && hit_data && data_fn && !led_hit && !adv_hit) |=>
        o_readdata == 32'h0000_0000)
        else $error("unimplemented register read not zero");
    refused_write_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (ext_wr && !led_hit && !adv_hit) |=>
        $stable({o_led_style_select, o_eee_adv_1000, o_eee_adv_100}))
        else $error("unimplemented register write changed state");
    portal_only_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (accept && i_write && !hit_data) |=>
        $stable({o_led_style_select, o_eee_adv_1000, o_eee_adv_100}) && $stable(reg_addr_ff))
        else $error("write outside the data word reached a register");
    addr_view_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (accept && i_read && hit_data && !data_fn) |=>
        o_readdata == {16'h0000, $past(reg_addr_ff)})
        else $error("address phase read did not return the register address");
    setup_view_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (accept && i_read && hit_setup) |=>
        (o_readdata & ~{16'h0000, ext_portal_pkg::SETUP_WMASK}) == 32'h0000_0000)
        else $error("setup read shows bits outside its fields");
    unmapped_bus_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (accept && i_read && !hit_setup && !hit_data) |=> o_readdata == 32'h0000_0000)
        else $error("unmapped bus read not zero");
    readdata_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !(accept && i_read) |=> $stable(o_readdata))
        else $error("read data changed without a read");
endmodule

// File: sim/ext_portal_tb.sv
/*
 * Self-checking bench for the extended register portal: Avalon-MM read and
 * write tasks, then sequences of portal accesses with expected values.
 * Assumes the portal answers each accepted access by dropping waitrequest.
 */
`timescale 1ns/10ps
module ext_portal_tb;
    // ========================================================================
    // Stimulus and observed signals
    // ========================================================================
    logic        i_core_clk;
    logic        i_nrst;
    logic [3:0]  i_address;
    logic        i_read;
    logic        i_write;
    logic [31:0] i_writedata;
    logic [3:0]  i_byteenable;
    logic [31:0] o_readdata;
    logic        o_waitrequest;
    logic        o_led_style_select;
    logic        o_eee_adv_1000;
    logic        o_eee_adv_100;
    logic [31:0] rd;
    int          err_total = 0;
    int          n_tests   = 0;
    int          cycles    = 0;

    ext_portal i_ext_portal (
        .i_core_clk        (i_core_clk),
        .i_nrst            (i_nrst),
        .i_address         (i_address),
        .i_read            (i_read),
        .i_write           (i_write),
        .i_writedata       (i_writedata),
        .i_byteenable      (i_byteenable),
        .o_readdata        (o_readdata),
        .o_waitrequest     (o_waitrequest),
        .o_led_style_select(o_led_style_select),
        .o_eee_adv_1000    (o_eee_adv_1000),
        .o_eee_adv_100     (o_eee_adv_100)
    );

    initial begin
        i_core_clk = 1'b0;
        i_nrst = 1'b0;
        i_address = 4'h0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0000_0000;
        i_byteenable = 4'hF;
    end

    always #20 i_core_clk = ~i_core_clk;

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask

    // Holds the request until waitrequest is sampled low, then releases it.
    task automatic bus_access(input logic wr, input logic [3:0] a, input logic [15:0] d);
        i_address <= a;
        i_writedata <= {16'h0000, d};
        i_write <= wr;
        i_read <= ~wr;
        @(posedge i_core_clk);
        while (o_waitrequest !== 1'b0) begin
            @(posedge i_core_clk);
        end
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        bus_access(1'b1, a, d);
    endtask

    task automatic rd_reg(input logic [3:0] a);
        bus_access(1'b0, a, 16'h0000);
    endtask

    task automatic do_reset;
        i_nrst <= 1'b0;
        repeat (20) @(posedge i_core_clk);
        check(32'(o_waitrequest), 32'h0000_0001);
        check(32'(o_led_style_select), 32'h0000_0000);
        check(32'({o_eee_adv_1000, o_eee_adv_100}), 32'h0000_0003);
        i_nrst <= 1'b1;
        @(posedge i_core_clk);
    endtask

    // ========================================================================
    // Test sequence
    // ========================================================================
    initial begin
        do_reset();
        $display("test reset values done");
        wr_reg(4'h0, 16'h0002);
        wr_reg(4'h4, 16'h0000);
        wr_reg(4'h0, 16'h4002);
        rd_reg(4'h4);
        check(rd, 32'h0000_0001);
        wr_reg(4'h4, 16'h0010);
        check(32'(o_led_style_select), 32'h0000_0001);
        rd_reg(4'h4);
        check(rd, 32'h0000_0011);
        wr_reg(4'h4, 16'hFFEF);
        rd_reg(4'h4);
        check(rd, 32'h0000_0001);
        check(32'(o_led_style_select), 32'h0000_0000);
        $display("test led register done");
        wr_reg(4'h0, 16'h0007);
        wr_reg(4'h4, 16'h003C);
        wr_reg(4'h0, 16'h8007);
        rd_reg(4'h4);
        check(rd, 32'h0000_0006);
        rd_reg(4'h4);
        check(rd, 32'h0000_0000);
        wr_reg(4'h0, 16'h0007);
        rd_reg(4'h4);
        check(rd, 32'h0000_003E);
        $display("test increment read done");
        wr_reg(4'h4, 16'h003B);
        wr_reg(4'h0, 16'h8007);
        wr_reg(4'h4, 16'h0000);
        wr_reg(4'h4, 16'hFFFB);
        check(32'({o_eee_adv_1000, o_eee_adv_100}), 32'h0000_0001);
        // The write in increment mode has moved the address on to 3Dh.
        wr_reg(4'h0, 16'h0007);
        rd_reg(4'h4);
        check(rd, 32'h0000_003D);
        wr_reg(4'h4, 16'h003C);
        wr_reg(4'h0, 16'h4007);
        rd_reg(4'h4);
        check(rd, 32'h0000_0002);
        rd_reg(4'h4);
        check(rd, 32'h0000_0002);
        $display("test increment write done");
        wr_reg(4'h0, 16'h0003);
        wr_reg(4'h4, 16'h0000);
        wr_reg(4'h0, 16'h4003);
        wr_reg(4'h4, 16'h0010);
        rd_reg(4'h4);
        check(rd, 32'h0000_0000);
        check(32'(o_led_style_select), 32'h0000_0000);
        wr_reg(4'h0, 16'hFFFF);
        rd_reg(4'h0);
        check(rd, 32'h0000_C01F);
        wr_reg(4'h8, 16'h1234);
        rd_reg(4'h8);
        check(rd, 32'h0000_0000);
        $display("test refused accesses done");
        // Set the led bit first so that the reset visibly clears it.
        wr_reg(4'h0, 16'h0002);
        wr_reg(4'h4, 16'h0000);
        wr_reg(4'h0, 16'h4002);
        wr_reg(4'h4, 16'h0010);
        check(32'(o_led_style_select), 32'h0000_0001);
        do_reset();
        rd_reg(4'h0);
        check(rd, 32'h0000_0000);
        rd_reg(4'h4);
        check(rd, 32'h0000_0000);
        $display("test mid-run reset done");
        close_out();
    end
endmodule
